// ===== sio_consts.svh
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH
`define SIO_SEL_CMD       3'h0
`define SIO_SEL_PORTA     3'h1
`define SIO_SEL_PORTB     3'h2
`define SIO_SEL_PORTC     3'h3
`define SIO_SEL_TMR_LO    3'h4
`define SIO_SEL_TMR_HI    3'h5
`define SIO_CMD_DIR_A     0
`define SIO_CMD_DIR_B     1
`define SIO_CMD_DIR_C     2
`define SIO_CMD_TMR_START 6
`define SIO_RESET_BYTE    8'h00
`define SIO_SHIFT_BITS    4'h8
`define SIO_SHIFT_LAST    4'hF
`define SIO_SLED_RESET    8'h50
`define SIO_SLED_DIR      0
`define SIO_SLED_PULSE    1
`define SIO_SLED_SP0      2
`define SIO_SLED_SP1      3
`define SIO_FOCUS_START   4
`define SIO_FOCUS_KICK    5
`define SIO_LASER_OFF     6
`endif

// ===== sio_pkg.sv
package sio_pkg;
    typedef logic [7:0] sio_byte_t;
    typedef enum logic [1:0] {
        SIO_IDLE,
        SIO_ADDR,
        SIO_DATA
    } sio_phase_e;
endpackage

// ===== sio_if.sv
`timescale 1ns/1ps
interface sio_if;
    logic [7:0] ad_m;
    logic [7:0] ad_m_oe_n;
    logic [7:0] ad_s;
    logic [7:0] ad_s_oe_n;
    logic       ale;
    logic       io_m;
    logic       rd_n;
    logic       wr_n;
    logic       timer_pulse;
    logic       sr_data;
    logic       sr_clk;
    logic [1:0] sr_strobe;
    logic       link_serial_data;
    logic       link_serial_clock;
    logic       link_acknowledge;
    modport proc (
        output ad_m, ad_m_oe_n, ale, io_m, rd_n, wr_n, sr_data, sr_clk, sr_strobe,
        output link_serial_data, link_serial_clock,
        input  ad_s, ad_s_oe_n, timer_pulse, link_acknowledge
    );
    modport dev (
        input  ad_m, ad_m_oe_n, ale, io_m, rd_n, wr_n, sr_data, sr_clk, sr_strobe,
        input  link_serial_data, link_serial_clock,
        output ad_s, ad_s_oe_n, timer_pulse, link_acknowledge
    );
endinterface

// ===== sio_expander.sv
`timescale 1ns/1ps
`include "sio_consts.svh"
module sio_expander
    import sio_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    sio_if.dev              bus,
    input  wire logic [7:0] port_a_in,
    input  wire logic [7:0] port_b_in,
    input  wire logic [5:0] port_c_in,
    output logic [7:0]      port_a_out,
    output logic [7:0]      port_a_oe_n,
    output logic [7:0]      port_b_out,
    output logic [7:0]      port_b_oe_n,
    output logic [5:0]      port_c_out,
    output logic [5:0]      port_c_oe_n,
    output logic [7:0]      sled_focus_laser,
    output logic [7:0]      aux_outputs
);
    typedef struct packed {
        logic        ale_q;
        logic        wr_q;
        logic        sck_q;
        logic [7:0]  addr;
        logic        io_sel;
        logic        ce;
        logic [7:0]  cmd;
        logic [7:0]  pa;
        logic [7:0]  pb;
        logic [5:0]  pc;
        logic [13:0] tmr_load;
        logic [13:0] tmr_cnt;
        logic        tmr_run;
        logic        tpulse;
        logic [7:0]  dout;
        logic        drive;
        logic [7:0]  sh0;
        logic [7:0]  sh1;
        logic [7:0]  par0;
        logic [7:0]  par1;
    } sio_dev_s;

    sio_dev_s  r;
    sio_dev_s  next_r;
    sio_byte_t ram [0:255];
    sio_byte_t ram_q;
    logic      ram_we;
    logic      ce_n_pin;

    assign ce_n_pin = 1'b0;

    function automatic sio_byte_t port_view(input logic [7:0] drv, input logic [7:0] inp, input logic [7:0] dir);
        port_view = (drv & dir) | (inp & ~dir);
    endfunction

    always_comb begin
        next_r = r;
        next_r.ale_q = bus.ale;
        next_r.wr_q = bus.wr_n;
        next_r.sck_q = bus.sr_clk;
        next_r.tpulse = 1'b0;
        ram_we = 1'b0;
        if (r.ale_q && !bus.ale) begin
            next_r.addr = bus.ad_m;
            next_r.io_sel = bus.io_m;
            next_r.ce = !ce_n_pin;
        end
        if (r.ce && !bus.wr_n && r.wr_q) begin
            if (!r.io_sel) begin
                ram_we = 1'b1;
            end else begin
                case (r.addr[2:0])
                    `SIO_SEL_CMD: begin
                        next_r.cmd = bus.ad_m;
                        if (bus.ad_m[`SIO_CMD_TMR_START]) begin
                            next_r.tmr_cnt = r.tmr_load;
                            next_r.tmr_run = (r.tmr_load != 14'h0000);
                        end
                    end
                    `SIO_SEL_PORTA: next_r.pa = bus.ad_m;
                    `SIO_SEL_PORTB: next_r.pb = bus.ad_m;
                    `SIO_SEL_PORTC: next_r.pc = bus.ad_m[5:0];
                    `SIO_SEL_TMR_LO: next_r.tmr_load[7:0] = bus.ad_m;
                    `SIO_SEL_TMR_HI: next_r.tmr_load[13:8] = bus.ad_m[5:0];
                    default: next_r.cmd = r.cmd;
                endcase
            end
        end
        if (r.tmr_run) begin
            next_r.tmr_cnt = r.tmr_cnt - 14'h0001;
            if (r.tmr_cnt == 14'h0001) begin
                next_r.tmr_run = 1'b0;
                next_r.tpulse = 1'b1;
            end
        end
        next_r.drive = r.ce && !bus.rd_n;
        if (!r.io_sel) begin
            next_r.dout = ram_q;
        end else begin
            case (r.addr[2:0])
                `SIO_SEL_CMD: next_r.dout = r.cmd;
                `SIO_SEL_PORTA: next_r.dout = port_view(r.pa, port_a_in, {8{r.cmd[`SIO_CMD_DIR_A]}});
                `SIO_SEL_PORTB: next_r.dout = port_view(r.pb, port_b_in, {8{r.cmd[`SIO_CMD_DIR_B]}});
                `SIO_SEL_PORTC: next_r.dout = port_view({2'b00, r.pc}, {2'b00, port_c_in},
                                                        {8{r.cmd[`SIO_CMD_DIR_C]}});
                `SIO_SEL_TMR_LO: next_r.dout = r.tmr_cnt[7:0];
                `SIO_SEL_TMR_HI: next_r.dout = {2'b00, r.tmr_cnt[13:8]};
                default: next_r.dout = `SIO_RESET_BYTE;
            endcase
        end
        // Data is sampled on the rising clock edge, first bit ends up in the MSB.
        if (!r.sck_q && bus.sr_clk) begin
            next_r.sh0 = {r.sh0[6:0], bus.sr_data};
            next_r.sh1 = {r.sh1[6:0], bus.sr_data};
        end
        if (bus.sr_strobe[0]) begin
            next_r.par0 = r.sh0;
        end
        if (bus.sr_strobe[1]) begin
            next_r.par1 = r.sh1;
        end
    end

    always_ff @(posedge clock) begin
        if (ram_we) begin
            ram[r.addr] <= bus.ad_m;
        end
        ram_q <= ram[r.addr];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            // Laser held off and focus in power-on state until software shifts a byte in.
            r.par0 <= `SIO_SLED_RESET;
            r.sh0 <= `SIO_SLED_RESET;
            // The write strobe idles high, so its edge detector starts high too, matching the strobe's idle level after reset.
            r.wr_q <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            port_a_out <= 8'h00;
            port_a_oe_n <= 8'hFF;
            port_b_out <= 8'h00;
            port_b_oe_n <= 8'hFF;
            port_c_out <= 6'h00;
            port_c_oe_n <= 6'h3F;
            sled_focus_laser <= `SIO_SLED_RESET;
            aux_outputs <= 8'h00;
            bus.ad_s <= 8'h00;
            bus.ad_s_oe_n <= 8'hFF;
            bus.timer_pulse <= 1'b0;
            bus.link_acknowledge <= 1'b0;
        end else begin
            port_a_out <= next_r.pa;
            port_a_oe_n <= {8{!next_r.cmd[`SIO_CMD_DIR_A]}};
            port_b_out <= next_r.pb;
            port_b_oe_n <= {8{!next_r.cmd[`SIO_CMD_DIR_B]}};
            port_c_out <= next_r.pc;
            port_c_oe_n <= {6{!next_r.cmd[`SIO_CMD_DIR_C]}};
            sled_focus_laser <= next_r.par0;
            aux_outputs <= next_r.par1;
            bus.ad_s <= next_r.dout;
            bus.ad_s_oe_n <= {8{!next_r.drive}};
            bus.timer_pulse <= next_r.tpulse;
            // Acknowledge echoes the sampled link clock so the sender can pace bits.
            bus.link_acknowledge <= bus.link_serial_clock;
        end
    end
endmodule

// ===== sio_processor.sv
`timescale 1ns/1ps
`include "sio_consts.svh"
module sio_processor
    import sio_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    sio_if.proc             bus,
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire logic       req_io,
    input  wire logic [7:0] req_addr,
    input  wire logic [7:0] req_data,
    input  wire logic       sr_valid,
    input  wire logic       sr_sel,
    input  wire logic [7:0] sr_byte,
    input  wire logic       link_bit,
    output logic            busy,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            timer_seen
);
    typedef struct packed {
        sio_phase_e ph;
        logic [2:0] cnt;
        logic       wr;
        logic [7:0] data;
        logic       sh_act;
        logic [3:0] sh_cnt;
        logic [7:0] sh;
        logic       sh_sel;
        logic       sh_stb;
    } sio_host_s;

    sio_host_s r;
    sio_host_s next_r;

    always_comb begin
        next_r = r;
        next_r.sh_stb = 1'b0;
        case (r.ph)
            SIO_IDLE: begin
                if (req_valid) begin
                    next_r.ph = SIO_ADDR;
                    next_r.wr = req_write;
                    next_r.data = req_data;
                    next_r.cnt = 3'h0;
                end
            end
            SIO_ADDR: begin
                next_r.cnt = r.cnt + 3'h1;
                if (r.cnt == 3'h2) begin
                    next_r.ph = SIO_DATA;
                    next_r.cnt = 3'h0;
                end
            end
            SIO_DATA: begin
                next_r.cnt = r.cnt + 3'h1;
                if (r.cnt == 3'h5) begin
                    next_r.ph = SIO_IDLE;
                end
            end
            default: next_r.ph = SIO_IDLE;
        endcase
        if (!r.sh_act && sr_valid) begin
            next_r.sh_act = 1'b1;
            next_r.sh = sr_byte;
            next_r.sh_sel = sr_sel;
            next_r.sh_cnt = 4'h0;
        end else if (r.sh_act) begin
            next_r.sh_cnt = r.sh_cnt + 4'h1;
            if (r.sh_cnt[0]) begin
                next_r.sh = {r.sh[6:0], 1'b0};
            end
            // Two half-cycles per bit, so the last high clock phase ends the byte.
            if (r.sh_cnt == `SIO_SHIFT_LAST) begin
                next_r.sh_act = 1'b0;
                next_r.sh_stb = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            busy <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            timer_seen <= 1'b0;
            bus.ad_m <= 8'h00;
            bus.ad_m_oe_n <= 8'hFF;
            bus.ale <= 1'b0;
            bus.io_m <= 1'b0;
            bus.rd_n <= 1'b1;
            bus.wr_n <= 1'b1;
            bus.sr_data <= 1'b0;
            bus.sr_clk <= 1'b0;
            bus.sr_strobe <= 2'b00;
            bus.link_serial_data <= 1'b0;
            bus.link_serial_clock <= 1'b0;
        end else begin
            r <= next_r;
            busy <= (next_r.ph != SIO_IDLE) || next_r.sh_act;
            rsp_valid <= (r.ph == SIO_DATA) && (r.cnt == 3'h5) && !r.wr;
            if ((r.ph == SIO_DATA) && (r.cnt == 3'h4)) begin
                rsp_data <= bus.ad_s;
            end
            timer_seen <= bus.timer_pulse;
            // Address and select are set up as the latch strobe rises, two cycles before it falls.
            if (r.ph == SIO_IDLE && req_valid) begin
                bus.ad_m <= req_addr;
                bus.io_m <= req_io;
                bus.ad_m_oe_n <= 8'h00;
                bus.ale <= 1'b1;
            end else if (next_r.ph == SIO_ADDR && r.cnt == 3'h1) begin
                bus.ale <= 1'b0;
            end
            if (next_r.ph == SIO_DATA && r.ph == SIO_ADDR) begin
                bus.ad_m <= r.data;
                bus.ad_m_oe_n <= r.wr ? 8'h00 : 8'hFF;
                bus.wr_n <= !r.wr;
                bus.rd_n <= r.wr;
            end
            if (r.ph == SIO_DATA && r.cnt == 3'h4) begin
                bus.wr_n <= 1'b1;
                bus.rd_n <= 1'b1;
            end
            if (next_r.ph == SIO_IDLE) begin
                bus.ad_m_oe_n <= 8'hFF;
            end
            bus.sr_data <= next_r.sh[7];
            bus.sr_clk <= next_r.sh_act && next_r.sh_cnt[0];
            bus.sr_strobe <= next_r.sh_stb ? (next_r.sh_sel ? 2'b10 : 2'b01) : 2'b00;
            bus.link_serial_data <= link_bit;
            bus.link_serial_clock <= !bus.link_serial_clock;
        end
    end
endmodule

// ===== sio_monitor.sv
`timescale 1ns/1ps
module sio_monitor (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [7:0] ad_m_oe_n,
    input wire logic [7:0] ad_s_oe_n,
    input wire logic       ale,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       timer_pulse,
    input wire logic [1:0] sr_strobe,
    input wire logic       link_serial_clock,
    input wire logic       link_acknowledge
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    a_strobe_excl: assert property (rd_n || wr_n)
        else $error("read and write strobes low together");
    a_ale_width: assert property ($rose(ale) |=> ale ##1 !ale)
        else $error("latch strobe width wrong");
    a_addr_first: assert property ($fell(ale) |-> (rd_n && wr_n) ##1 (rd_n ^ wr_n))
        else $error("data strobe too close to address phase");
    a_wr_hold: assert property ($fell(wr_n) |-> (!wr_n && ad_m_oe_n == 8'h00) [*5] ##1 wr_n)
        else $error("write phase shape wrong");
    a_rd_drive: assert property ($fell(rd_n) |=> ad_s_oe_n == 8'h00)
        else $error("expander not driving during read");
    a_no_clash: assert property ((~ad_m_oe_n & ~ad_s_oe_n) == 8'h00)
        else $error("both ends drive the bus");
    a_rd_release: assert property (rd_n [*2] |-> ad_s_oe_n == 8'hFF)
        else $error("expander drives bus outside read");
    a_timer_once: assert property (timer_pulse |=> !timer_pulse)
        else $error("timer pulse longer than one cycle");
    a_strobe_one: assert property (sr_strobe != 2'b00 |-> $onehot(sr_strobe) ##1 sr_strobe == 2'b00)
        else $error("register strobe not a single pulse");
    a_link_echo: assert property (link_acknowledge == $past(link_serial_clock))
        else $error("link acknowledge does not follow link clock");
    c_write: cover property ($fell(wr_n));
    c_read: cover property ($fell(rd_n));
    c_timer: cover property (timer_pulse);
    c_shift: cover property (sr_strobe != 2'b00);
endmodule

// ===== servo_io_expansion_tb_top.sv
`timescale 1ns/1ps
module servo_io_expansion_tb_top
    import sio_pkg::*;
;
    typedef struct packed {
        logic      w;
        logic      io;
        sio_byte_t a;
        sio_byte_t d;
    } sio_row_s;
    logic       clock, reset_n, req_valid, req_write, req_io;
    logic       sr_valid, sr_sel, link_bit, busy, rsp_valid, timer_seen;
    sio_byte_t  req_addr, req_data, sr_byte, port_a_in, port_b_in, rsp_data, rd;
    sio_byte_t  port_a_out, port_a_oe_n, port_b_out, port_b_oe_n, sled_focus_laser, aux_outputs;
    logic [5:0] port_c_in, port_c_out, port_c_oe_n;
    int         fails, n_checks, cyc, n_tmr;
    sio_row_s   rows [11] = '{'{1'b1, 1'b1, 8'h00, 8'h07}, '{1'b1, 1'b1, 8'h01, 8'hA5},
        '{1'b1, 1'b1, 8'h02, 8'h3C}, '{1'b1, 1'b1, 8'h03, 8'h2A}, '{1'b0, 1'b1, 8'h00, 8'h07},
        '{1'b1, 1'b0, 8'h00, 8'h11}, '{1'b1, 1'b0, 8'hFF, 8'hEE}, '{1'b0, 1'b0, 8'h00, 8'h11},
        '{1'b0, 1'b0, 8'hFF, 8'hEE}, '{1'b1, 1'b1, 8'h06, 8'h55}, '{1'b0, 1'b1, 8'h06, 8'h00}};
    sio_if bus ();
    sio_expander u_sio_expander (.clock(clock), .reset_n(reset_n), .bus(bus), .port_a_in(port_a_in),
        .port_b_in(port_b_in), .port_c_in(port_c_in), .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
        .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n), .port_c_out(port_c_out),
        .port_c_oe_n(port_c_oe_n), .sled_focus_laser(sled_focus_laser), .aux_outputs(aux_outputs));
    sio_processor u_sio_processor (.clock(clock), .reset_n(reset_n), .bus(bus), .req_valid(req_valid),
        .req_write(req_write), .req_io(req_io), .req_addr(req_addr), .req_data(req_data),
        .sr_valid(sr_valid), .sr_sel(sr_sel), .sr_byte(sr_byte), .link_bit(link_bit), .busy(busy),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .timer_seen(timer_seen));
    sio_monitor u_sio_monitor (.clock(clock), .reset_n(reset_n), .ad_m_oe_n(bus.ad_m_oe_n),
        .ad_s_oe_n(bus.ad_s_oe_n), .ale(bus.ale), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .timer_pulse(bus.timer_pulse), .sr_strobe(bus.sr_strobe), .link_serial_clock(bus.link_serial_clock),
        .link_acknowledge(bus.link_acknowledge));
    task automatic chk(input sio_byte_t seen, input sio_byte_t exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // A request is held until the edge that takes it, then the bench waits out busy.
    task automatic do_req(input logic w, input logic io, input sio_byte_t a, input sio_byte_t d);
        logic got;
        @(posedge clock);
        #2;
        req_valid = 1'b1;
        req_write = w;
        req_io = io;
        req_addr = a;
        req_data = d;
        @(posedge clock);
        #2;
        req_valid = 1'b0;
        got = w;
        for (int k = 0; k < 40; k++) begin
            @(posedge clock);
            #1;
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                rd = rsp_data;
            end
            if (busy === 1'b0 && got) break;
        end
    endtask
    task automatic do_sr(input logic s, input sio_byte_t b);
        @(posedge clock);
        #2;
        sr_valid = 1'b1;
        sr_sel = s;
        sr_byte = b;
        @(posedge clock);
        #2;
        sr_valid = 1'b0;
        for (int k = 0; k < 60; k++) begin
            @(posedge clock);
            #1;
            if (bus.sr_strobe != 2'b00) break;
        end
        repeat (2) @(posedge clock);
        #1;
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (timer_seen === 1'b1) n_tmr++;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        reset_n = 1'b0;
        {req_valid, req_write, req_io, sr_valid, sr_sel} = 5'h00;
        {req_addr, req_data, sr_byte} = 24'h000000;
        port_a_in = 8'h96;
        port_b_in = 8'h69;
        port_c_in = 6'h15;
        link_bit = 1'b1;
        repeat (4) @(posedge clock);
        #2;
        reset_n = 1'b1;
        chk(sled_focus_laser, 8'h50);
        chk(port_a_oe_n, 8'hFF);
        chk(aux_outputs, 8'h00);
        foreach (rows[i]) begin
            do_req(rows[i].w, rows[i].io, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].d);
        end
        chk(port_a_out, 8'hA5);
        chk(port_b_out, 8'h3C);
        chk({2'b00, port_c_out}, 8'h2A);
        chk({2'b00, port_c_oe_n}, 8'h00);
        chk(port_b_oe_n, 8'h00);
        chk({7'h00, bus.link_serial_data}, {7'h00, link_bit});
        do_req(1'b1, 1'b1, 8'h00, 8'h00);
        chk(port_a_oe_n, 8'hFF);
        do_req(1'b0, 1'b1, 8'h01, 8'h00);
        chk(rd, 8'h96);
        do_req(1'b0, 1'b1, 8'h02, 8'h00);
        chk(rd, 8'h69);
        do_sr(1'b0, 8'h3A);
        chk(sled_focus_laser, 8'h3A);
        chk(aux_outputs, 8'h00);
        do_sr(1'b1, 8'hC5);
        chk(aux_outputs, 8'hC5);
        chk(sled_focus_laser, 8'h3A);
        do_req(1'b1, 1'b1, 8'h04, 8'h05);
        do_req(1'b1, 1'b1, 8'h05, 8'h00);
        n_tmr = 0;
        do_req(1'b1, 1'b1, 8'h00, 8'h40);
        repeat (30) @(posedge clock);
        chk(8'(n_tmr), 8'h01);
        #2;
        reset_n = 1'b0;
        #5;
        chk(sled_focus_laser, 8'h50);
        @(posedge clock);
        #2;
        reset_n = 1'b1;
        chk(port_a_oe_n, 8'hFF);
        do_req(1'b0, 1'b0, 8'h00, 8'h00);
        chk(rd, 8'h11);
        close_out();
    end
endmodule
